// file: hw/uisp_core.v
// USB event flags, request merge, pull controls and APB slave
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "uisp_map.vh"

module uisp_core #(
  parameter PIPES = 10,
  parameter ATTACH_CYC = `UISP_ATTACH_CYC
) (
  input wire clk,
  input wire srst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // Pins from outside the clock domain
  input wire vbus_sense_pin,
  input wire overcurrent_in_port0,
  input wire overcurrent_in_port1,
  // Protocol engine status and event strobes (same clock)
  input wire suspended,
  input wire [1:0] line_state,
  input wire [1:0] port_speed_state,
  input wire sofNewFrame,
  input wire [2:0] device_state_field,
  input wire devStateEvent,
  input wire [2:0] control_stage_field,
  input wire ctrlStageEvent,
  input wire [PIPES-1:0] pipeEmptyEvent,
  input wire [PIPES-1:0] pipeStallEvent,
  input wire [PIPES-1:0] pipeRespFailEvent,
  input wire [PIPES-1:0] pipeNakEvent,
  input wire [PIPES-1:0] pipeReadyEvent,
  input wire detachEvent,
  input wire eofErrorEvent,
  input wire setupAckEvent,
  input wire setupFailEvent,
  input wire portableDetect,
  // Pad controls
  output wire port_line_pulldown_en,
  output wire vbusPulldownConnect,
  // Requests to the interrupt controller
  output wire usbMainReq,
  output wire usbResumeReq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [31:0] usb_misc_control_ff; // Role, pull-down and VBUS cut bits
  reg [15:0] evFlag_ff; // Sticky event flags
  reg [15:0] evEnable_ff; // Event enables
  reg [PIPES-1:0] pipeEnable_ff; // Per-pipe enables
  reg [2:0] vbusSync_ff, ovc0Sync_ff, ovc1Sync_ff; // Two sync stages plus history
  reg [1:0] lineDly_ff; // Previous line state
  reg [1:0] lineSuspDly_ff; // Previous line state, used by the suspended resume check
  reg [15:0] attachCnt_ff; // Attach debounce counter
  reg attachDone_ff; // Attach already reported for this connection
  reg [1:0] failCnt_ff [0:PIPES-1]; // Consecutive response failures per pipe
  reg [1:0] setupFailCnt_ff; // Consecutive setup failures
  reg portableDly_ff; // Previous portable detect level
  reg [15:0] evSet; // Event pulses this cycle
  reg [PIPES-1:0] nrdySet; // Not-ready pulses per pipe

  wire hostRole = usb_misc_control_ff[`UISP_CTRL_HOST];
  wire vbusLvl = vbusSync_ff[1];
  wire ovc0Lvl = ovc0Sync_ff[1];
  wire ovc1Lvl = ovc1Sync_ff[1];
  wire wrEn = psel && penable && pwrite;
  wire [PIPES-1:0] emptyFlags, notReadyFlags, readyFlags;
  wire emptyAny, notReadyAny, readyAny;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Stage 0 is only read by stage 1; stage 2 holds history for edges
  always @(posedge clk) begin
    if (srst) begin
      vbusSync_ff <= 3'h0;
      ovc0Sync_ff <= 3'h0;
      ovc1Sync_ff <= 3'h0;
    end else begin
      vbusSync_ff <= {vbusSync_ff[1:0], vbus_sense_pin};
      ovc0Sync_ff <= {ovc0Sync_ff[1:0], overcurrent_in_port0};
      ovc1Sync_ff <= {ovc1Sync_ff[1:0], overcurrent_in_port1};
    end
  end

  // ----------------------------------------------------------------
  // Pad controls
  // ----------------------------------------------------------------
  // RQ1 port line pull-down
  assign port_line_pulldown_en = usb_misc_control_ff[`UISP_CTRL_PD1];
  // RQ2 RQ3 VBUS pull-down kept unless cut bit is 1
  assign vbusPulldownConnect = ~usb_misc_control_ff[`UISP_CTRL_VBCUT];

  // ----------------------------------------------------------------
  // History registers for edge and sequence detection
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      lineDly_ff <= 2'h0;
      lineSuspDly_ff <= 2'h0;
      portableDly_ff <= 1'b0;
      setupFailCnt_ff <= 2'h0;
    end else begin
      lineDly_ff <= line_state;
      lineSuspDly_ff <= line_state;
      portableDly_ff <= portableDetect;
      // RQ20 consecutive setup failures, reset by ACK
      if (setupAckEvent || setupFailCnt_ff == `UISP_FAIL_LIMIT) begin
        setupFailCnt_ff <= 2'h0;
      end else if (setupFailEvent) begin
        setupFailCnt_ff <= setupFailCnt_ff + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Attach debounce: J (01) or K (10) held for the attach time
  // ----------------------------------------------------------------
  wire jkState = (line_state == 2'h1) || (line_state == 2'h2);
  wire jkStable = jkState && (line_state == lineDly_ff);
  always @(posedge clk) begin
    if (srst) begin
      attachCnt_ff <= 16'h0000;
      attachDone_ff <= 1'b0;
    end else if (!hostRole || !jkStable) begin
      // Any change restarts the measurement
      attachCnt_ff <= 16'h0000;
      attachDone_ff <= 1'b0;
    end else if (!attachDone_ff) begin
      if (attachCnt_ff == ATTACH_CYC[15:0] - 16'h0001) begin
        attachDone_ff <= 1'b1;
      end
      attachCnt_ff <= attachCnt_ff + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Per-pipe response failure counters
  // ----------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < PIPES; gp = gp + 1) begin : gFail
      // RQ12 three consecutive failures in host role
      always @(posedge clk) begin
        if (srst) begin
          failCnt_ff[gp] <= 2'h0;
        end else if (pipeStallEvent[gp] || failCnt_ff[gp] == `UISP_FAIL_LIMIT) begin
          failCnt_ff[gp] <= 2'h0;
        end else if (pipeRespFailEvent[gp] && hostRole) begin
          failCnt_ff[gp] <= failCnt_ff[gp] + 2'h1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Event condition decode
  // ----------------------------------------------------------------
  integer i;
  always @* begin
    evSet = 16'h0000;
    for (i = 0; i < PIPES; i = i + 1) begin
      // RQ12 STALL or third failure in host, NAK in peripheral
      nrdySet[i] = hostRole ? (pipeStallEvent[i] || failCnt_ff[i] == `UISP_FAIL_LIMIT)
                            : pipeNakEvent[i];
    end
    // RQ4 RQ6 VBUS edge flagged in peripheral role only; the level register shows the pin in both roles
    evSet[`UISP_EV_VBUS] = !hostRole && (vbusSync_ff[2] != vbusLvl);
    // RQ7 J to K or J to SE0 while suspended, peripheral only
    evSet[`UISP_EV_RESUME_IRQ] = !hostRole && suspended && lineSuspDly_ff == 2'h1 &&
                           (line_state == 2'h2 || line_state == 2'h0);
    // RQ8 new frame number sent or received
    evSet[`UISP_EV_SOF] = sofNewFrame;
    // RQ9 device state transition
    evSet[`UISP_EV_DEV_STATE_IRQ] = !hostRole && devStateEvent;
    // RQ10 control stage transition
    evSet[`UISP_EV_CTRL_STAGE_IRQ] = !hostRole && ctrlStageEvent;
    // RQ14 overcurrent edges on either port, host only
    evSet[`UISP_EV_OVRC] = hostRole && ((ovc0Sync_ff[2] != ovc0Lvl) ||
                                        (ovc1Sync_ff[2] != ovc1Lvl));
    // RQ15 line state change
    evSet[`UISP_EV_BUS_CHANGE_IRQ] = line_state != lineDly_ff;
    // RQ16 detach
    evSet[`UISP_EV_DETACH_IRQ] = hostRole && detachEvent;
    // RQ17 attach once per stable period
    evSet[`UISP_EV_ATCH] = hostRole && jkStable && !attachDone_ff &&
                           attachCnt_ff == ATTACH_CYC[15:0] - 16'h0001;
    // RQ18 EOF error
    evSet[`UISP_EV_EOFE] = hostRole && eofErrorEvent;
    // RQ19 setup ACK
    evSet[`UISP_EV_SETUP_ACK_IRQ] = hostRole && setupAckEvent;
    // RQ20 third setup failure
    evSet[`UISP_EV_SERR] = hostRole && setupFailCnt_ff == `UISP_FAIL_LIMIT;
    // RQ21 portable device connected
    evSet[`UISP_EV_PDET] = hostRole && portableDetect && !portableDly_ff;
  end

  // ----------------------------------------------------------------
  // Per-pipe flag banks
  // ----------------------------------------------------------------
  // RQ11 buffer empty
  uisp_pipe_flags #(.PIPES(PIPES)) uEmpty (
    .clk(clk),
    .srst(srst),
    .setPulse(pipeEmptyEvent),
    .clrWrite(wrEn && paddr == `UISP_OFF_PEMP),
    .clrData(pwdata[PIPES-1:0]),
    .enable(pipeEnable_ff),
    .flags(emptyFlags),
    .anyActive(emptyAny)
  );

  // RQ12 not ready
  uisp_pipe_flags #(.PIPES(PIPES)) uNotReady (
    .clk(clk),
    .srst(srst),
    .setPulse(nrdySet),
    .clrWrite(wrEn && paddr == `UISP_OFF_PNRD),
    .clrData(pwdata[PIPES-1:0]),
    .enable(pipeEnable_ff),
    .flags(notReadyFlags),
    .anyActive(notReadyAny)
  );

  // RQ13 buffer ready
  uisp_pipe_flags #(.PIPES(PIPES)) uReady (
    .clk(clk),
    .srst(srst),
    .setPulse(pipeReadyEvent),
    .clrWrite(wrEn && paddr == `UISP_OFF_PRDY),
    .clrData(pwdata[PIPES-1:0]),
    .enable(pipeEnable_ff),
    .flags(readyFlags),
    .anyActive(readyAny)
  );

  // Pipe summaries are live; they drop once software clears pipe bits
  wire [15:0] evLive = {8'h00, readyAny, notReadyAny, emptyAny, 5'h00};

  // ----------------------------------------------------------------
  // Sticky flags and writable registers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      usb_misc_control_ff <= `UISP_CTRL_RST;
      evEnable_ff <= 16'h0000;
      pipeEnable_ff <= {PIPES{1'b0}};
      evFlag_ff <= 16'h0000;
    end else begin
      if (wrEn && paddr == `UISP_OFF_CTRL) begin
        usb_misc_control_ff <= pwdata & 32'h0000_0083;
      end
      if (wrEn && paddr == `UISP_OFF_ENAB) begin
        evEnable_ff <= pwdata[15:0];
      end
      if (wrEn && paddr == `UISP_OFF_PENB) begin
        pipeEnable_ff <= pwdata[PIPES-1:0];
      end
      // RQ23 write 0 clears, new events win over the clear
      if (wrEn && paddr == `UISP_OFF_STAT) begin
        evFlag_ff <= (evFlag_ff & pwdata[15:0]) | evSet;
      end else begin
        evFlag_ff <= evFlag_ff | evSet;
      end
    end
  end

  // ----------------------------------------------------------------
  // Request outputs
  // ----------------------------------------------------------------
  wire [15:0] evStatus = evFlag_ff | evLive;
  // RQ5 gated by enable
  wire [15:0] evActive = evStatus & evEnable_ff;
  // RQ22 main request covers all, resume only five sources
  assign usbMainReq = |evActive;
  assign usbResumeReq = |(evActive & `UISP_RESUME_MASK);

  // ----------------------------------------------------------------
  // APB read path; zero wait states, no error response
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Live levels: VBUS, overcurrent, line, port, device and control fields
  wire [31:0] levelWord = {18'h00000, portableDetect, control_stage_field,
                           device_state_field, port_speed_state, line_state,
                           ovc1Lvl, ovc0Lvl, vbusLvl};

  // Read data registered in the setup cycle so it is valid in access
  always @(posedge clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `UISP_OFF_CTRL: prdata <= usb_misc_control_ff;
        `UISP_OFF_STAT: prdata <= {16'h0000, evStatus};
        `UISP_OFF_ENAB: prdata <= {16'h0000, evEnable_ff};
        // RQ6 RQ14 RQ15 RQ16 RQ21 level status
        `UISP_OFF_LEVEL: prdata <= levelWord;
        `UISP_OFF_PEMP: prdata <= {{(32-PIPES){1'b0}}, emptyFlags};
        `UISP_OFF_PNRD: prdata <= {{(32-PIPES){1'b0}}, notReadyFlags};
        `UISP_OFF_PRDY: prdata <= {{(32-PIPES){1'b0}}, readyFlags};
        `UISP_OFF_PENB: prdata <= {{(32-PIPES){1'b0}}, pipeEnable_ff};
        // Unmapped reads return zero
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // uisp_core

// file: hw/uisp_map.vh
// Register map, fields and timing counts of the USB event logic
// Summary of operation
// RQ1 - Port 1 pull-down bit: 0 open, 1 down
// RQ2 - VBUS pull-down stays on while cut bit 0
// RQ3 - Cut bit 1 removes VBUS pull-down
// RQ4 - Host role ignores VBUS sense input; host role gates only the VBUS event, level status still shown
// RQ5 - Request only when flag and enable set
// RQ6 - VBUS edges flag event, level status shown
// RQ7 - Peripheral suspended: J to K/SE0 resumes
// RQ8 - New SOF frame number flags event
// RQ9 - Peripheral state transitions flagged, 3-bit state
// RQ10 - Control stage transitions flagged, 3-bit stage
// RQ11 - Per-pipe buffer empty or oversize flagged
// RQ12 - Per-pipe NAK/STALL/three errors flag not-ready
// RQ13 - Per-pipe buffer ready flagged
// RQ14 - Host overcurrent pin edges flagged, monitor shown
// RQ15 - Line state change flagged, state shown
// RQ16 - Host detach flagged, port state shown
// RQ17 - Host attach after 2.5 us J/K
// RQ18 - Host EOF error flagged
// RQ19 - Host setup ACK flagged
// RQ20 - Host three setup failures flag error
// RQ21 - Host portable device detect flagged, status shown
// RQ22 - Main request all; resume request five
// RQ23 - Flags sticky until software clears them
`ifndef UISP_MAP_VH
`define UISP_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define UISP_OFF_CTRL 12'h000
`define UISP_OFF_STAT 12'h004
`define UISP_OFF_ENAB 12'h008
`define UISP_OFF_LEVEL 12'h00C
`define UISP_OFF_PEMP 12'h010
`define UISP_OFF_PNRD 12'h014
`define UISP_OFF_PRDY 12'h018
`define UISP_OFF_PENB 12'h01C

// ----------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------
`define UISP_CTRL_HOST 0
`define UISP_CTRL_PD1 1
`define UISP_CTRL_VBCUT 7
`define UISP_CTRL_RST 32'h0000_0000

// ----------------------------------------------------------------
// Event flag positions in status and enable registers
// ----------------------------------------------------------------
`define UISP_EV_VBUS 0
`define UISP_EV_RESUME_IRQ 1
`define UISP_EV_SOF 2
`define UISP_EV_DEV_STATE_IRQ 3
`define UISP_EV_CTRL_STAGE_IRQ 4
`define UISP_EV_BUFFER_EMPTY_IRQ 5
`define UISP_EV_BUFFER_NOT_READY_IRQ 6
`define UISP_EV_BUFFER_READY_IRQ 7
`define UISP_EV_OVRC 8
`define UISP_EV_BUS_CHANGE_IRQ 9
`define UISP_EV_DETACH_IRQ 10
`define UISP_EV_ATCH 11
`define UISP_EV_EOFE 12
`define UISP_EV_SETUP_ACK_IRQ 13
`define UISP_EV_SERR 14
`define UISP_EV_PDET 15
`define UISP_EV_NUM 16
`define UISP_RESUME_MASK 16'h8303

// ----------------------------------------------------------------
// Level register fields
// ----------------------------------------------------------------
`define UISP_LV_VBUS 0
`define UISP_LV_OVC_LO 1
`define UISP_LV_LINE_STATE_LO 3
`define UISP_LV_PORT_LO 5
`define UISP_LV_DVSQ_LO 7
`define UISP_LV_CTSQ_LO 10
`define UISP_LV_PDET 13

// ----------------------------------------------------------------
// Timing: attach debounce, 2.5 us at 200 MHz
// ----------------------------------------------------------------
`define UISP_ATTACH_NS 2500
`define UISP_CLK_NS 5
`define UISP_ATTACH_CYC ((`UISP_ATTACH_NS + `UISP_CLK_NS - 1) / `UISP_CLK_NS)
`define UISP_FAIL_LIMIT 2'h3

`endif

// file: hw/uisp_pipe_flags.v
// Sticky per-pipe event flags with write-zero-to-clear
`timescale 1ns/1ps

module uisp_pipe_flags #(
  parameter PIPES = 10
) (
  input wire clk,
  input wire srst,
  input wire [PIPES-1:0] setPulse,
  input wire clrWrite,
  input wire [PIPES-1:0] clrData,
  input wire [PIPES-1:0] enable,
  output wire [PIPES-1:0] flags,
  output wire anyActive
);

  // Flag storage
  reg [PIPES-1:0] flag_ff;

  // ----------------------------------------------------------------
  // One flag per pipe
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PIPES; gi = gi + 1) begin : gPipe
      // RQ23 sticky pipe flag: set wins over a concurrent clear
      always @(posedge clk) begin
        if (srst) begin
          flag_ff[gi] <= 1'b0;
        end else if (setPulse[gi]) begin
          flag_ff[gi] <= 1'b1;
        end else if (clrWrite && !clrData[gi]) begin
          // Writing 0 clears, writing 1 leaves others untouched
          flag_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign flags = flag_ff;
  // Summary feeds one event bit; per-pipe enables gate it
  assign anyActive = |(flag_ff & enable);

endmodule // uisp_pipe_flags

// file: verification/tb_usb_irq_sources_and_bus_pulls.sv
// Self-checking bench for the USB event logic over APB
`timescale 1ns/1ps
`include "uisp_map.vh"

module tb_usb_irq_sources_and_bus_pulls;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, go, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] code;
  logic vbus_sense_pin, overcurrent_in_port0, overcurrent_in_port1, suspended;
  logic [1:0] line_state;
  logic [2:0] device_state_field, control_stage_field;
  logic portableDetect, sofNewFrame, devStateEvent, ctrlStageEvent, detachEvent;
  logic eofErrorEvent, setupAckEvent, setupFailEvent;
  logic [9:0] pipeEmptyEvent, pipeNakEvent, pipeReadyEvent, pipeStallEvent, pipeRespFailEvent;
  logic port_line_pulldown_en, vbusPulldownConnect, usbMainReq, usbResumeReq;
  int miscompares, check_count;
  // Entry: role bit, model command, expected flags
  localparam logic [21:0] TBL [23] = '{22'h00_0004, 22'h20_0004, 22'h01_0008,
    22'h21_0000, 22'h02_0010, 22'h03_0000, 22'h23_0400, 22'h24_1000, 22'h25_2000,
    22'h2F_2000, 22'h26_4000, 22'h07_0001, 22'h27_0000, 22'h28_0100, 22'h08_0000,
    22'h29_8000, 22'h0A_0020, 22'h0B_0040, 22'h30_0040, 22'h31_0040, 22'h2C_0080,
    22'h0D_0202, 22'h2E_0A00};

  uisp_core #(.ATTACH_CYC(8)) DUT (.*, .port_speed_state(2'h0));
  uisp_usb_side #(.PIPES(10)) u_side (.*);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Bench tasks
  // ----------------------------------------------------------------
  task print_verdict;
    $display("Comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, seen);
      miscompares++;
    end
  endtask
  // Setup then access; one idle cycle after
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    rd = prdata;
    if (n == 50) begin
      miscompares++;
      print_verdict;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task kick(input logic [4:0] c);
    int n;
    n = 0;
    go <= 1'b1;
    code <= c;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy === 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n == 100) begin
      miscompares++;
      print_verdict;
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata, go, code} = '0;
    srst = 1'b1;
    miscompares = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("line_pd", port_line_pulldown_en, 0);
    chk("vbus_pd", vbusPulldownConnect, 1);
    apb(0, `UISP_OFF_CTRL, 0);
    chk("ctrl_rst", rd, `UISP_CTRL_RST);
    apb(1, `UISP_OFF_CTRL, 32'hFFFF_FFFF);
    apb(0, `UISP_OFF_CTRL, 0);
    chk("ctrl_bits", rd, 32'h0000_0083);
    chk("line_pd", port_line_pulldown_en, 1);
    chk("vbus_pd", vbusPulldownConnect, 0);
    apb(1, `UISP_OFF_CTRL, 0);
    chk("vbus_pd", vbusPulldownConnect, 1);
    apb(0, 12'h100, 0);
    chk("unmapped", rd, 0);
    $display("Test pulls done");
    apb(1, `UISP_OFF_ENAB, 32'h0000_FFFF);
    apb(1, `UISP_OFF_PENB, 32'h0000_0001);
    foreach (TBL[i]) begin
      apb(1, `UISP_OFF_CTRL, {31'h0, TBL[i][21]});
      repeat (12) @(posedge clk);
      apb(1, `UISP_OFF_STAT, 0);
      apb(1, `UISP_OFF_PEMP, 0);
      apb(1, `UISP_OFF_PNRD, 0);
      apb(1, `UISP_OFF_PRDY, 0);
      kick(TBL[i][20:16]);
      repeat (6) @(posedge clk);
      apb(0, `UISP_OFF_STAT, 0);
      chk("stat", rd, {16'h0, TBL[i][15:0]});
      chk("main", usbMainReq, TBL[i][15:0] != 0);
      chk("resume", usbResumeReq, (TBL[i][15:0] & `UISP_RESUME_MASK) != 0);
    end
    apb(0, `UISP_OFF_LEVEL, 0);
    chk("level", rd, 32'h0000_2508);
    $display("Test events done");
    apb(1, `UISP_OFF_ENAB, 0);
    apb(1, `UISP_OFF_CTRL, 1);
    apb(1, `UISP_OFF_STAT, 0);
    kick(5'd3);
    chk("masked", usbMainReq, 0);
    apb(1, `UISP_OFF_STAT, 32'h0000_FFFF);
    apb(1, `UISP_OFF_ENAB, 32'h0000_0400);
    chk("unmasked", usbMainReq, 1);
    apb(0, `UISP_OFF_STAT, 0);
    chk("sticky", rd, 32'h0000_0400);
    apb(1, `UISP_OFF_STAT, 0);
    chk("cleared", usbMainReq, 0);
    $display("Test mask done");
    print_verdict;
  end
endmodule // tb_usb_irq_sources_and_bus_pulls

// file: verification/uisp_core_asserts.sv
// Port-level checker for the USB event logic
`timescale 1ns/1ps
`include "uisp_map.vh"

module uisp_core_asserts (
  input logic clk,
  input logic srst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic pready,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic vbus_sense_pin,
  input logic overcurrent_in_port0,
  input logic detachEvent,
  input logic setupAckEvent,
  input logic port_line_pulldown_en,
  input logic vbusPulldownConnect,
  input logic usbMainReq,
  input logic usbResumeReq
);
  // ----------------------------------------------------------------
  // Shadow of role and enables
  // ----------------------------------------------------------------
  wire wrAcc = psel && penable && pwrite && pready; // Completed write
  wire ctrlWr = wrAcc && (paddr == `UISP_OFF_CTRL); // Control write
  logic host_ff; // Host role copy
  logic [15:0] enable_ff; // Enable copy
  // Copies track the slave's own write edge, so no skew
  always @(posedge clk) begin
    if (srst) begin
      host_ff <= 1'b0;
      enable_ff <= 16'h0000;
    end else if (ctrlWr) begin
      host_ff <= pwdata[0];
    end else if (wrAcc && paddr == `UISP_OFF_ENAB) begin
      enable_ff <= pwdata[15:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_LINE_PD: assert property (ctrlWr |=> port_line_pulldown_en == $past(pwdata[1]))
    else $error("line pull-down mismatch");
  AST_VB_CUT: assert property (ctrlWr |=> vbusPulldownConnect == !$past(pwdata[7]))
    else $error("vbus pull-down mismatch");
  AST_VB_DEF: assert property (disable iff (1'b0) srst |=> vbusPulldownConnect)
    else $error("vbus pull-down off after reset");
  AST_PULL_HOLD: assert property (!ctrlWr |=> $stable({vbusPulldownConnect,
    port_line_pulldown_en})) else $error("pull control moved without a write");
  AST_NO_EN: assert property (enable_ff == 16'h0000 |-> !usbMainReq)
    else $error("request with all enables clear");
  AST_RES_SUB: assert property (usbResumeReq |-> usbMainReq)
    else $error("resume request without main request");
  AST_RES_MASK: assert property ((enable_ff & `UISP_RESUME_MASK) == 16'h0000
    |-> !usbResumeReq) else $error("resume request from masked event");
  AST_STICKY: assert property (usbMainReq && !(wrAcc && !ctrlWr) |=> usbMainReq)
    else $error("request dropped without a software write");
  AST_SETUP_ACK_IRQ: assert property (setupAckEvent && host_ff && enable_ff[13] |=> usbMainReq)
    else $error("setup ack did not raise request");
  AST_DETACH_IRQ: assert property (detachEvent && host_ff && enable_ff[10] |=> usbMainReq)
    else $error("detach did not raise request");
  AST_VBUS: assert property ($changed(vbus_sense_pin) && !host_ff && enable_ff[0]
    |-> ##[1:5] usbResumeReq) else $error("vbus edge missed");
  AST_OVC: assert property ($changed(overcurrent_in_port0) && host_ff && enable_ff[8]
    |-> ##[1:5] usbResumeReq) else $error("overcurrent edge missed");
endmodule // uisp_core_asserts

bind uisp_core uisp_core_asserts u_chk (.*);

// file: verification/uisp_usb_side.sv
// Far-side model: engine strobes and USB pins on command
`timescale 1ns/1ps

module uisp_usb_side #(
  parameter PIPES = 10
) (
  input logic clk,
  input logic go,
  input logic [4:0] code,
  output logic busy,
  output logic vbus_sense_pin,
  output logic overcurrent_in_port0,
  output logic overcurrent_in_port1,
  output logic suspended,
  output logic [1:0] line_state,
  output logic [2:0] device_state_field,
  output logic [2:0] control_stage_field,
  output logic portableDetect,
  output logic sofNewFrame,
  output logic devStateEvent,
  output logic ctrlStageEvent,
  output logic detachEvent,
  output logic eofErrorEvent,
  output logic setupAckEvent,
  output logic setupFailEvent,
  output logic [PIPES-1:0] pipeEmptyEvent,
  output logic [PIPES-1:0] pipeNakEvent,
  output logic [PIPES-1:0] pipeReadyEvent,
  output logic [PIPES-1:0] pipeStallEvent,
  output logic [PIPES-1:0] pipeRespFailEvent
);
  logic [6:0] pls; // One-cycle engine strobes
  logic [4:0] pp; // Pipe 0 strobes
  assign {setupFailEvent, setupAckEvent, eofErrorEvent, detachEvent, ctrlStageEvent,
    devStateEvent, sofNewFrame} = pls;
  assign pipeEmptyEvent = PIPES'(pp[0]);
  assign pipeNakEvent = PIPES'(pp[1]);
  assign pipeReadyEvent = PIPES'(pp[2]);
  assign pipeStallEvent = PIPES'(pp[3]);
  assign pipeRespFailEvent = PIPES'(pp[4]);
  // Strobe then a gap, so repeats stay separate events
  task fire(input logic [6:0] m, input logic [4:0] q);
    pls <= m;
    pp <= q;
    @(posedge clk);
    pls <= 7'h00;
    pp <= 5'h00;
    @(posedge clk);
  endtask
  task hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // Command loop
  // ----------------------------------------------------------------
  initial begin
    {pls, pp, busy, vbus_sense_pin, overcurrent_in_port0, overcurrent_in_port1} = '0;
    {suspended, line_state, device_state_field, control_stage_field, portableDetect} = '0;
    forever begin
      @(posedge clk);
      if (go === 1'b1) begin
        busy <= 1'b1;
        case (code)
          0: fire(7'h01, 4'h0);
          1: begin
            device_state_field <= device_state_field + 3'h1;
            fire(7'h02, 4'h0);
          end
          2: begin
            control_stage_field <= control_stage_field + 3'h1;
            fire(7'h04, 4'h0);
          end
          3: fire(7'h08, 4'h0);
          4: fire(7'h10, 4'h0);
          5: fire(7'h20, 4'h0);
          6: repeat (3) fire(7'h40, 4'h0);
          7: begin
            vbus_sense_pin <= ~vbus_sense_pin;
            hold(1);
          end
          8: begin
            overcurrent_in_port0 <= ~overcurrent_in_port0;
            overcurrent_in_port1 <= ~overcurrent_in_port1;
            hold(1);
          end
          9: begin
            portableDetect <= ~portableDetect;
            hold(1);
          end
          10: fire(7'h00, 4'h1);
          11: fire(7'h00, 4'h2);
          12: fire(7'h00, 4'h4);
          // Suspended bus goes J then K
          13: begin
            suspended <= 1'b1;
            line_state <= 2'h1;
            hold(4);
            line_state <= 2'h2;
            hold(4);
          end
          // Idle bus then J held past the debounce
          14: begin
            line_state <= 2'h0;
            hold(4);
            line_state <= 2'h1;
            hold(20);
          end
          // Two failures, an ack restarts the count, one more failure
          15: begin
            repeat (2) fire(7'h40, 4'h0);
            fire(7'h20, 4'h0);
            fire(7'h40, 4'h0);
          end
          16: fire(7'h00, 5'h08);
          // Three missing responses in a row
          17: repeat (3) fire(7'h00, 5'h10);
          default: hold(1);
        endcase
        busy <= 1'b0;
      end
    end
  end
endmodule // uisp_usb_side
